// file: common/spdif_tx_format_map.vh
// Constants for the transmitter format control block: register place,
// field positions, reset value, word-length codes and bus answers.
// Assumes inclusion by bare name from the design files.
`ifndef SPDIF_TX_FORMAT_MAP_VH
`define SPDIF_TX_FORMAT_MAP_VH

// ==========================================================
// Register placement
// ==========================================================
`define TXF_REG_INDEX 12'h08e
`define TXF_REG_ADDR 12'h238
`define TXF_ADDR_W 12
`define TXF_REG_RESET 16'h002d
`define TXF_REG_W 16

// ==========================================================
// Field positions
// ==========================================================
`define TXF_FREQ_MSB 7
`define TXF_FREQ_LSB 4
`define TXF_WLMAX_BIT 3
`define TXF_WLC_MSB 2
`define TXF_WLC_LSB 0
`define TXF_RSVD_MSB 15
`define TXF_RSVD_LSB 8

// ==========================================================
// Channel status frequency codes
// ==========================================================
`define TXF_FREQ_44K1 4'h0
`define TXF_FREQ_48K 4'h2
`define TXF_FREQ_32K 4'h3

// ==========================================================
// Word length codes and bit counts
// ==========================================================
`define TXF_WLC_FULL 3'h5
`define TXF_WLC_LESS1 3'h4
`define TXF_WLC_LESS2 3'h2
`define TXF_WLC_LESS3 3'h6
`define TXF_WLC_LESS4 3'h1
`define TXF_BITS_MAX24 5'h18
`define TXF_BITS_MAX20 5'h14

// ==========================================================
// Sample path and bus answers
// ==========================================================
`define TXF_SAMPLE_W 24
`define TXF_FIFO_DEPTH 4
`define TXF_FIFO_PTR_W 2
`define TXF_RESP_OKAY 2'h0
`define TXF_RESP_SLVERR 2'h2

`endif

// file: hw/sample_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps

module sample_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter PTR_W = 2
) (
    input wire clk_sys,
    input wire reset,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    // ==========================================================
    // Storage and pointers
    // ==========================================================
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_reg;
    reg [PTR_W-1:0] rd_ptr_reg;
    reg [PTR_W:0] count_reg;
    wire push;
    wire pop;

    // Full and empty come from the count, so both stay honest
    assign in_ready = (count_reg != DEPTH[PTR_W:0]);
    assign out_valid = (count_reg != {(PTR_W+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Data array has no reset; only valid entries are ever read
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointer and count update
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= {PTR_W{1'b0}};
            rd_ptr_reg <= {PTR_W{1'b0}};
            count_reg <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // sample_fifo

// file: hw/spdif_tx_format_control.v
// Format control register of the digital audio transmitter, with an
// AXI4-Lite slave and the sample path it shapes (FIFO plus formatter).
// Assumes a 100 MHz clk_sys, synchronous inputs, one AXI4-Lite master.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spdif_tx_format_map.vh"

// What this block does
// - Bits 7..4 drive transmitted channel status frequency
// - Frequency field never changes sample transmit rate
// - Bit 3 picks 20 or 24 bit maximum
// - Bits 2..0 give valid bits, up to the maximum picked by bit 3
// - Reset value 0x002D: 48 kHz, 24 bits
module spdif_tx_format_control (
    input wire clk_sys,
    input wire reset,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Incoming samples, MSB aligned in 24 bits
    input wire [23:0] sample_in_data,
    input wire sample_in_valid,
    output reg sample_in_ready,
    // Formatted samples toward the frame encoder
    output reg [23:0] sample_out_data,
    output reg sample_out_valid,
    input wire sample_out_ready,
    // Settings for the channel status and word length logic
    output reg [3:0] cs_freq_code,
    output reg word_len_max24,
    output reg [4:0] valid_bit_count
);
    // Full-width copies of the map constants, so they can be sliced on purpose
    localparam [15:0] RESET_WORD = `TXF_REG_RESET;
    localparam [11:0] REG_BYTE_ADDR = `TXF_REG_ADDR;

    // ==========================================================
    // Decoding functions
    // ==========================================================

    // Valid bits per word; an unlisted code keeps the full width
    function [4:0] decode_bits;
        input max24;
        input [2:0] code;
        reg [4:0] top;
        begin
            top = max24 ? `TXF_BITS_MAX24 : `TXF_BITS_MAX20;
            case (code)
                `TXF_WLC_FULL: decode_bits = top;
                `TXF_WLC_LESS1: decode_bits = top - 5'h01;
                `TXF_WLC_LESS2: decode_bits = top - 5'h02;
                `TXF_WLC_LESS3: decode_bits = top - 5'h03;
                `TXF_WLC_LESS4: decode_bits = top - 5'h04;
                default: decode_bits = top;
            endcase
        end
    endfunction

    // Keeps the top 'bits' positions of an MSB-aligned 24-bit word
    function [23:0] keep_mask;
        input [4:0] bits;
        begin
            keep_mask = ~(24'hffffff >> bits);
        end
    endfunction

    // Register decode shared by the write and the read path
    function hits_reg;
        input [11:0] addr;
        begin
            hits_reg = (addr[11:2] == REG_BYTE_ADDR[11:2]);
        end
    endfunction

    // ==========================================================
    // Control register
    // ==========================================================
    reg [7:0] ctrl_reg; // Reserved upper byte is not stored
    reg [11:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;
    wire do_write;

    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

    // Write channels are taken in either order and held until both are in
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_reg <= RESET_WORD[7:0];
            aw_addr_reg <= 12'h000;
            aw_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TXF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (hits_reg(aw_addr_reg)) begin
                    s_axi_bresp <= `TXF_RESP_OKAY;
                    // Upper byte lane only reaches reserved bits; dropped
                    if (w_strb_reg[0]) begin
                        ctrl_reg <= w_data_reg[7:0];
                    end
                end else begin
                    s_axi_bresp <= `TXF_RESP_SLVERR;
                end
            end
            // Ready reopens only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================

    // One read at a time; reserved bits read as zero
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TXF_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                if (hits_reg(s_axi_araddr)) begin
                    s_axi_rdata <= {24'h000000, ctrl_reg};
                    s_axi_rresp <= `TXF_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `TXF_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Settings toward status bits and formatter
    // ==========================================================
    wire [4:0] bits_now;

    assign bits_now = decode_bits(ctrl_reg[`TXF_WLMAX_BIT], ctrl_reg[`TXF_WLC_MSB:`TXF_WLC_LSB]);

    // Status outputs lag the register by one cycle, as all outputs are flops
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cs_freq_code <= `TXF_FREQ_48K;
            word_len_max24 <= 1'b1;
            valid_bit_count <= `TXF_BITS_MAX24;
        end else begin
            cs_freq_code <= ctrl_reg[`TXF_FREQ_MSB:`TXF_FREQ_LSB];
            word_len_max24 <= ctrl_reg[`TXF_WLMAX_BIT];
            valid_bit_count <= bits_now;
        end
    end

    // ==========================================================
    // Sample path
    // ==========================================================
    wire [23:0] fifo_in_data;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [23:0] fifo_out_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire take_sample;

    assign fifo_in_data = sample_in_data;
    assign fifo_in_valid = sample_in_valid & sample_in_ready;

    sample_fifo #(
        .WIDTH(`TXF_SAMPLE_W),
        .DEPTH(`TXF_FIFO_DEPTH),
        .PTR_W(`TXF_FIFO_PTR_W)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_data(fifo_in_data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // Pace set only by the downstream ready; frequency code never enters
    assign fifo_out_ready = ~sample_out_valid | sample_out_ready;
    assign take_sample = fifo_out_valid & fifo_out_ready;

    // Input ready is registered, so it looks one push ahead of the FIFO
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sample_in_ready <= 1'b0;
        end else begin
            sample_in_ready <= fifo_in_ready & ~(fifo_in_valid & ~take_sample);
        end
    end

    // Output stage truncates the word to its valid bits
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sample_out_data <= 24'h000000;
            sample_out_valid <= 1'b0;
        end else begin
            if (take_sample) begin
                sample_out_data <= fifo_out_data & keep_mask(bits_now);
                sample_out_valid <= 1'b1;
            end else if (sample_out_ready) begin
                sample_out_valid <= 1'b0;
            end
        end
    end
endmodule // spdif_tx_format_control

// file: sim/sample_sink.sv
// Receiver model for the formatted sample stream.
// Assumes the bench seeds randomness and drives slow.
`timescale 1ns/1ps
// ========================================
// Sample receiver
module sample_sink (
    input wire clk_sys,
    input wire reset,
    input wire [23:0] sample_out_data,
    input wire sample_out_valid,
    output logic sample_out_ready,
    input wire slow
);
    logic [23:0] got[$];
    initial sample_out_ready = 1'b0;
    // Ready on a random one cycle in four when slow, so the FIFO backs up
    always @(posedge clk_sys) begin
        if (!reset && sample_out_valid && sample_out_ready)
            got.push_back(sample_out_data);
        sample_out_ready <= !reset && (!slow || $urandom_range(3) == 0);
    end
endmodule // sample_sink

// file: sim/spdif_tx_format_control_assertions.sv
// Port assertions for the transmitter format control block.
// Assumes one clk_sys domain with async active-high reset.
`timescale 1ns/1ps
`include "spdif_tx_format_map.vh"
// ========================================
// Checker
module spdif_tx_format_checker (
    input wire clk_sys,
    input wire reset,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [23:0] sample_out_data,
    input wire sample_out_valid,
    input wire sample_out_ready,
    input wire [3:0] cs_freq_code,
    input wire word_len_max24,
    input wire [4:0] valid_bit_count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Both channels taken at one edge; the bench offers them together
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire wr_reg = wr_take && s_axi_awaddr == `TXF_REG_ADDR && s_axi_wstrb[0];
    chk_reset_value: assert property ($fell(reset) |-> cs_freq_code == 4'h2
        && word_len_max24 && valid_bit_count == 5'h18) else $error("bad reset settings");
    chk_count_range: assert property (
        valid_bit_count - (word_len_max24 ? 5'h14 : 5'h10) <= 5'h4) else $error("bad count");
    chk_out_masked: assert property (
        sample_out_valid |-> 24'(sample_out_data << valid_bit_count) == 24'h0)
        else $error("low sample bits not zero");
    // Settings show three edges after the take: store, then output register
    chk_field_store: assert property (wr_reg |-> ##3
        cs_freq_code == $past(s_axi_wdata[7:4], 3) && word_len_max24 == $past(s_axi_wdata[3], 3))
        else $error("settings not taken from write");
    chk_rsvd_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    // Take, then the store edge raises the answer: seen two edges on
    chk_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("no write answer");
    chk_read_clear: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
    chk_out_hold: assert property (sample_out_valid && !sample_out_ready
        |=> sample_out_valid && $stable(sample_out_data)) else $error("stalled sample dropped");
    // Main scenarios reached
    cover property (wr_reg);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (sample_out_valid && !sample_out_ready);
endmodule // spdif_tx_format_checker

bind spdif_tx_format_control spdif_tx_format_checker i_chk (.*);

// file: sim/spdif_tx_format_control_tb.sv
// Bench: register access over AXI4-Lite, settings outputs, masked samples.
// Assumes the design, sample_sink and the checker compile alongside.
`timescale 1ns/1ps
`include "spdif_tx_format_map.vh"
// ========================================
// Bench top
module spdif_tx_format_control_tb;
    logic clk_sys = 1'b0, reset = 1'b1, slow = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sample_in_valid = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [23:0] sample_in_data = 24'h0;
    logic [7:0] reg_m = 8'h2d;
    logic [23:0] exp_q[$];
    int fails = 0, samples_checked = 0, cycles = 0;
    int dn[8] = '{0, 4, 2, 0, 1, 0, 3, 0};
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire sample_in_ready, sample_out_valid, sample_out_ready, word_len_max24;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [23:0] sample_out_data;
    wire [3:0] cs_freq_code;
    wire [4:0] valid_bit_count;
    spdif_tx_format_control i_dut (.*);
    sample_sink i_sink (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // Cycle count; the ceiling cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            summarize;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Unlisted codes keep the full width
    function automatic logic [4:0] nbits(input logic [7:0] r);
        return 5'((r[3] ? 24 : 20) - dn[r[2:0]]);
    endfunction
    // A clock edge first, so no strobe is assigned twice in one step
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, e);
        check(s_axi_rresp, er);
    endtask
    task automatic cfg_check;
        @(posedge clk_sys);
        check(cs_freq_code, reg_m[7:4]);
        check(word_len_max24, reg_m[3]);
        check(valid_bit_count, nbits(reg_m));
    endtask
    // Six random samples through the FIFO; cycles taken returned
    task automatic run(output int cyc);
        logic [23:0] d;
        int t;
        t = cycles;
        for (int i = 0; i < 6; i++) begin
            d = 24'($urandom);
            sample_in_data <= d;
            sample_in_valid <= 1'b1;
            do @(posedge clk_sys); while (!sample_in_ready);
            exp_q.push_back(d & ~(24'hffffff >> nbits(reg_m)));
        end
        sample_in_valid <= 1'b0;
        // Looked at mid-cycle, so the sink's push at the edge has settled
        while (i_sink.got.size() < exp_q.size()) @(negedge clk_sys);
        cyc = cycles - t;
        while (exp_q.size() > 0) check(i_sink.got.pop_front(), exp_q.pop_front());
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ========================================
    // Main sequence: every frequency, length limit and length code
    initial begin
        int base, c;
        logic [7:0] r;
        void'($urandom(32'h2ee9));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        cfg_check;
        axi_read(`TXF_REG_ADDR, 32'h2d, `TXF_RESP_OKAY);
        run(base);
        axi_write(12'h23c, 8'hff, 4'h1, `TXF_RESP_SLVERR);
        axi_write(`TXF_REG_ADDR, 8'h30, 4'he, `TXF_RESP_OKAY);
        axi_read(12'h23c, 32'h0, `TXF_RESP_SLVERR);
        axi_read(`TXF_REG_ADDR, 32'h2d, `TXF_RESP_OKAY);
        for (int k = 0; k < 16; k++) begin
            r = {4'(k % 3 == 0 ? 0 : k % 3 + 1), 4'(k)};
            slow <= k[0];
            axi_write(`TXF_REG_ADDR, r, 4'h1, `TXF_RESP_OKAY);
            reg_m = r;
            cfg_check;
            axi_read(`TXF_REG_ADDR, {24'h0, r}, `TXF_RESP_OKAY);
            run(c);
            if (!k[0]) check(c, base);
        end
        // Reset after the last run must bring the defaults back and the same pace
        @(posedge clk_sys);
        reset <= 1'b1;
        slow <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        reg_m = 8'h2d;
        cfg_check;
        axi_read(`TXF_REG_ADDR, 32'h2d, `TXF_RESP_OKAY);
        run(c);
        check(c, base);
        summarize;
    end
endmodule // spdif_tx_format_control_tb
